// file: core/vid_fix.v
// stream corrector: code remap, timing words, line numbers, crcs, quality flags
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "vid_fix_map.vh"
module vid_fix (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// apb slave
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata_r,
	output reg pready_r,
	output reg pslverr_r,
	// device pins, asynchronous
	input wire proc_enable_pin,
	input wire flywheel_enable_pin,
	input wire rate_select,
	// upstream status and flywheel timing
	input wire smpte_mode,
	input wire fw_eav,
	input wire fw_sav,
	input wire fw_f,
	input wire fw_v,
	input wire fw_h,
	input wire fw_active,
	input wire [10:0] fw_line,
	input wire ap_range,
	input wire ff_range,
	input wire rx_h,
	// upstream words
	input wire [9:0] luma_in,
	input wire [9:0] chroma_in,
	// downstream words and indicators
	output reg [9:0] luma_out_r,
	output reg [9:0] chroma_out_r,
	output reg h_blank_out_r,
	output reg luma_anc_indicator_r,
	output reg chroma_anc_indicator_r
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function [9:0] remap;
		input [9:0] w;
		input act;
		begin
			remap = w;
			if (w >= `LIM_HI)
				remap = act ? `W_HI : `W_ONES;
			else if (w <= `LIM_LO)
				remap = act ? `W_LO : `W_ZERO;
		end
	endfunction

	function [9:0] crc_lo;
		input [17:0] c;
		begin
			crc_lo = {~c[8], c[8:0]};
		end
	endfunction

	function [9:0] crc_hi;
		input [17:0] c;
		begin
			crc_hi = {~c[17], c[17:9]};
		end
	endfunction

	function [15:0] merge;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] be;
		input [15:0] mask;
		begin
			merge[15:8] = be[1] ? wd[15:8] : old[15:8];
			merge[7:0] = be[0] ? wd[7:0] : old[7:0];
			merge = merge & mask;
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg [2:0] pin_m_r;
	reg [2:0] pin_s_r;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_m_r <= 3'h0;
			pin_s_r <= 3'h0;
		end else begin
			pin_m_r <= {proc_enable_pin, flywheel_enable_pin, rate_select};
			pin_s_r <= pin_m_r;
		end
	end
	wire proc_s = pin_s_r[2];
	wire fwen_s = pin_s_r[1];
	wire hd = !pin_s_r[0];

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [15:0] dis_r;
	reg [15:0] match_r;
	reg [14:0] qflags_r;
	wire [9:0] widx = paddr[11:2];
	wire hit_dis = (widx == `IDX_DISABLE);
	wire hit_flg = (widx == `IDX_FLAGS);
	wire hit_mat = (widx == `IDX_MATCH1);
	wire mapped = hit_dis || hit_flg || hit_mat;
	wire acc = psel && penable && !pready_r;
	wire done = psel && penable && pready_r;
	reg [31:0] rd;

	always @* begin
		rd = {`RST16, `RST16};
		if (hit_dis)
			rd[15:0] = dis_r;
		else if (hit_flg)
			rd[14:0] = qflags_r;
		else if (hit_mat)
			rd[15:0] = match_r;
	end

	// wait state lets read data come from a flop
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_r <= 1'b0;
			prdata_r <= {`RST16, `RST16};
			pslverr_r <= 1'b0;
			dis_r <= `RST16;
			match_r <= `RST16;
		end else begin
			pready_r <= acc;
			if (acc) begin
				prdata_r <= pwrite ? {`RST16, `RST16} : rd;
				pslverr_r <= !mapped;
			end
			if (done && pwrite && hit_dis)
				dis_r <= merge(dis_r, pwdata, pstrb, `DIS_WMASK);
			if (done && pwrite && hit_mat)
				match_r <= merge(match_r, pwdata, pstrb, `MATCH_WMASK);
		end
	end

	// ----------------------------------------------------------------
	// feature enables
	// ----------------------------------------------------------------
	wire proc_on = smpte_mode && proc_s;
	wire remap_on = proc_on && !dis_r[`B_REMAP];
	wire fcrc_on = proc_on && !hd && !dis_r[`B_FCRC];
	wire asum_on = proc_on && !dis_r[`B_ASUM];
	wire lcrc_on = proc_on && hd && !dis_r[`B_LCRC];
	wire lnum_on = proc_on && hd && !dis_r[`B_LNUM];
	wire trs_on = proc_on && fwen_s && !dis_r[`B_TRS];

	// ----------------------------------------------------------------
	// word position from flywheel timing
	// ----------------------------------------------------------------
	reg [3:0] cnt_r;
	reg eav_r;
	wire [3:0] cur = (fw_eav || fw_sav) ? `POS_0 : cnt_r;
	wire cur_eav = fw_eav || (!fw_sav && eav_r);
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= `POS_MAX;
			eav_r <= 1'b0;
		end else begin
			cnt_r <= (cur == `POS_MAX) ? cur : cur + 4'h1;
			eav_r <= cur_eav;
		end
	end

	// ----------------------------------------------------------------
	// stage a: remap, timing words, line numbers
	// ----------------------------------------------------------------
	reg [9:0] trs_w;
	reg [9:0] a_y_nxt;
	reg [9:0] a_c_nxt;
	wire [9:0] ln0 = {~fw_line[6], fw_line[6:0], 2'b00};
	wire [9:0] ln1 = {4'h8, fw_line[10:7], 2'b00};
	wire a_lce_nxt = hd && (cur_eav ? (cur == `POS_LN0 || cur == `POS_LN1) : (cur > `POS_XYZ));

	always @* begin
		case (cur)
		`POS_0: trs_w = `W_ONES;
		`POS_XYZ: trs_w = {1'b1, fw_f, fw_v, cur_eav, fw_v ^ cur_eav, fw_f ^ cur_eav,
			fw_f ^ fw_v, fw_f ^ fw_v ^ cur_eav, 2'b00};
		default: trs_w = `W_ZERO;
		endcase
		a_y_nxt = luma_in;
		a_c_nxt = chroma_in;
		if (remap_on) begin
			a_y_nxt = remap(luma_in, fw_active);
			a_c_nxt = remap(chroma_in, fw_active);
		end
		if (trs_on && cur <= `POS_XYZ) begin
			a_y_nxt = trs_w;
			if (hd)
				a_c_nxt = trs_w;
		end
		if (lnum_on && cur_eav && cur == `POS_LN0) begin
			a_y_nxt = ln0;
			a_c_nxt = ln0;
		end
		if (lnum_on && cur_eav && cur == `POS_LN1) begin
			a_y_nxt = ln1;
			a_c_nxt = ln1;
		end
	end

	reg [9:0] a_y_r;
	reg [9:0] a_c_r;
	reg [3:0] a_cnt_r;
	reg a_eav_r;
	reg a_lce_r;
	reg a_lcc_r;
	reg a_ap_r;
	reg a_ff_r;
	reg a_h_r;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			a_y_r <= `W_ZERO;
			a_c_r <= `W_ZERO;
			a_cnt_r <= `POS_MAX;
			a_eav_r <= 1'b0;
			a_lce_r <= 1'b0;
			a_lcc_r <= 1'b0;
			a_ap_r <= 1'b0;
			a_ff_r <= 1'b0;
			a_h_r <= 1'b0;
		end else begin
			a_y_r <= a_y_nxt;
			a_c_r <= a_c_nxt;
			a_cnt_r <= cur;
			a_eav_r <= cur_eav;
			a_lce_r <= a_lce_nxt;
			a_lcc_r <= fw_sav;
			a_ap_r <= ap_range;
			a_ff_r <= ff_range;
			a_h_r <= dis_r[`B_HCFG] ? rx_h : fw_h;
		end
	end

	// ----------------------------------------------------------------
	// stage b: ancillary packets, crc accumulation
	// ----------------------------------------------------------------
	wire [9:0] by_w;
	wire [9:0] bc_w;
	wire y_ind;
	wire c_ind;
	wire y_edh_end;
	wire y_edh_ok;
	wire [14:0] y_edh_set;
	wire [17:0] ap_crc;
	wire [17:0] ff_crc;
	wire [17:0] ly_crc;
	wire [17:0] lc_crc;

	anc_fix u_anc_y (
		.clk(clk),
		.arst_n(arst_n),
		.sum_fix_on(asum_on),
		.match_did(match_r[9:0]),
		.edh_fix_on(fcrc_on),
		.edh_chk_on(!hd),
		.ap_crc(ap_crc[15:0]),
		.ff_crc(ff_crc[15:0]),
		.d_in(a_y_r),
		.d_out_r(by_w),
		.ind_r(y_ind),
		.edh_end_r(y_edh_end),
		.edh_ok_r(y_edh_ok),
		.edh_set_r(y_edh_set)
	);

	// field crc packets ride the luma words only
	anc_fix u_anc_c (
		.clk(clk),
		.arst_n(arst_n),
		.sum_fix_on(asum_on),
		.match_did(match_r[9:0]),
		.edh_fix_on(1'b0),
		.edh_chk_on(1'b0),
		.ap_crc(`RST16),
		.ff_crc(`RST16),
		.d_in(a_c_r),
		.d_out_r(bc_w),
		.ind_r(c_ind),
		.edh_end_r(),
		.edh_ok_r(),
		.edh_set_r()
	);

	reg [3:0] b_cnt_r;
	reg b_eav_r;
	reg b_lce_r;
	reg b_lcc_r;
	reg b_ap_r;
	reg b_ff_r;
	reg b_h_r;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			b_cnt_r <= `POS_MAX;
			b_eav_r <= 1'b0;
			b_lce_r <= 1'b0;
			b_lcc_r <= 1'b0;
			b_ap_r <= 1'b0;
			b_ff_r <= 1'b0;
			b_h_r <= 1'b0;
		end else begin
			b_cnt_r <= a_cnt_r;
			b_eav_r <= a_eav_r;
			b_lce_r <= a_lce_r;
			b_lcc_r <= a_lcc_r;
			b_ap_r <= a_ap_r;
			b_ff_r <= a_ff_r;
			b_h_r <= a_h_r;
		end
	end

	// field sums restart after each error-detection packet, so they cover the next field
	crc_acc u_crc_ap (
		.clk(clk),
		.arst_n(arst_n),
		.clr(y_edh_end),
		.en(!hd && b_ap_r),
		.line_mode(1'b0),
		.d(by_w),
		.crc_r(ap_crc)
	);

	crc_acc u_crc_ff (
		.clk(clk),
		.arst_n(arst_n),
		.clr(y_edh_end),
		.en(!hd && b_ff_r),
		.line_mode(1'b0),
		.d(by_w),
		.crc_r(ff_crc)
	);

	crc_acc u_crc_ly (
		.clk(clk),
		.arst_n(arst_n),
		.clr(b_lcc_r),
		.en(b_lce_r),
		.line_mode(1'b1),
		.d(by_w),
		.crc_r(ly_crc)
	);

	crc_acc u_crc_lc (
		.clk(clk),
		.arst_n(arst_n),
		.clr(b_lcc_r),
		.en(b_lce_r),
		.line_mode(1'b1),
		.d(bc_w),
		.crc_r(lc_crc)
	);

	// ----------------------------------------------------------------
	// stage c: line crc insertion, outputs, quality flags
	// ----------------------------------------------------------------
	reg [9:0] c_y;
	reg [9:0] c_c;
	always @* begin
		c_y = by_w;
		c_c = bc_w;
		if (lcrc_on && b_eav_r && b_cnt_r == `POS_CRC0) begin
			c_y = crc_lo(ly_crc);
			c_c = crc_lo(lc_crc);
		end
		if (lcrc_on && b_eav_r && b_cnt_r == `POS_CRC1) begin
			c_y = crc_hi(ly_crc);
			c_c = crc_hi(lc_crc);
		end
	end

	// flags load on the edge where the indicator drops
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			luma_out_r <= `W_ZERO;
			chroma_out_r <= `W_ZERO;
			h_blank_out_r <= 1'b0;
			luma_anc_indicator_r <= 1'b0;
			chroma_anc_indicator_r <= 1'b0;
			qflags_r <= `RST15;
		end else begin
			luma_out_r <= c_y;
			chroma_out_r <= c_c;
			h_blank_out_r <= b_h_r;
			luma_anc_indicator_r <= y_ind;
			chroma_anc_indicator_r <= c_ind;
			if (y_edh_ok)
				qflags_r <= y_edh_set;
		end
	end
endmodule
`default_nettype wire

// file: shared/vid_fix_map.vh
// register map, field layouts and code values of the stream corrector
`ifndef VID_FIX_MAP_VH
`define VID_FIX_MAP_VH
// register word indices, byte address is index times four
`define IDX_DISABLE 10'h000
`define IDX_FLAGS 10'h003
`define IDX_MATCH1 10'h005
`define DIS_WMASK 16'h013F
`define MATCH_WMASK 16'h03FF
`define RST16 16'h0000
`define RST15 15'h0000
`define RST9 9'h000
`define RST8 8'h00
`define RST5 5'h00
// correction-disable bit positions, plus the blanking source select (B_HCFG)
`define B_HCFG 8
`define B_REMAP 5
`define B_FCRC 4
`define B_ASUM 3
`define B_LCRC 2
`define B_LNUM 1
`define B_TRS 0
// code values
`define W_HI 10'h3FB
`define W_LO 10'h004
`define W_ONES 10'h3FF
`define W_ZERO 10'h000
`define LIM_HI 10'h3FC
`define LIM_LO 10'h003
`define EDH_DID 10'h1F4
// crc polynomials, bit-reversed for lsb-first shifting
`define POLY_LINE 18'h23000
`define POLY_EDH 18'h08408
`define RST18 18'h00000
// word positions after a timing reference start
`define POS_0 4'h0
`define POS_XYZ 4'h3
`define POS_LN0 4'h4
`define POS_LN1 4'h5
`define POS_CRC0 4'h6
`define POS_CRC1 4'h7
`define POS_MAX 4'hF
// error-detection packet user words and flag fields
`define UDW_FFCRC 5'h03
`define UDW_ANC 5'h06
`define UDW_AP 5'h07
`define UDW_FF 5'h08
`define F_RX 6:2
`define F_ANC 14:10
`define F_FF 9:5
`define F_AP 4:0
`endif

// file: core/crc_acc.v
// running crc over 10-bit words, line crc or field crc polynomial
`timescale 1ns/1ps
`default_nettype none
`include "vid_fix_map.vh"
module crc_acc (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// control
	input wire clr,
	input wire en,
	input wire line_mode,
	// word in, remainder out
	input wire [9:0] d,
	output reg [17:0] crc_r
);
	function [17:0] step;
		input [17:0] c;
		input [9:0] w;
		input [17:0] poly;
		integer i;
		reg [17:0] t;
		begin
			t = c;
			for (i = 0; i < 10; i = i + 1) begin
				if (t[0] ^ w[i])
					t = (t >> 1) ^ poly;
				else
					t = t >> 1;
			end
			step = t;
		end
	endfunction

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			crc_r <= `RST18;
		else if (clr)
			crc_r <= `RST18;
		else if (en)
			crc_r <= step(crc_r, d, line_mode ? `POLY_LINE : `POLY_EDH);
	end
endmodule
`default_nettype wire

// file: core/anc_fix.v
// ancillary packet parser: checksum rewrite, field crc insert, flag capture
`timescale 1ns/1ps
`default_nettype none
`include "vid_fix_map.vh"
module anc_fix (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// control
	input wire sum_fix_on,
	input wire [9:0] match_did,
	input wire edh_fix_on,
	input wire edh_chk_on,
	input wire [15:0] ap_crc,
	input wire [15:0] ff_crc,
	// stream
	input wire [9:0] d_in,
	output reg [9:0] d_out_r,
	output reg ind_r,
	output reg edh_end_r,
	output reg edh_ok_r,
	output reg [14:0] edh_set_r
);
	localparam [7:0] S_IDLE = 8'h01;
	localparam [7:0] S_A1 = 8'h02;
	localparam [7:0] S_A2 = 8'h04;
	localparam [7:0] S_DID = 8'h08;
	localparam [7:0] S_SDID = 8'h10;
	localparam [7:0] S_DC = 8'h20;
	localparam [7:0] S_UDW = 8'h40;
	localparam [7:0] S_SUM = 8'h80;
	reg [7:0] st_r;
	reg [8:0] sum_r;
	reg [7:0] left_r;
	reg [4:0] idx_r;
	reg edh_r;
	reg fix_r;
	reg bad_r;
	reg [9:0] w;
	reg [9:0] exp_w;
	wire did_hit = (match_did == `W_ZERO) || (d_in == match_did);
	wire edh_in = (d_in == `EDH_DID);
	wire crc_pos = edh_r && (idx_r < `UDW_ANC);

	function [9:0] crc_word;
		input [15:0] c;
		input [4:0] k;
		begin
			case (k)
			5'h00: crc_word = {2'b01, c[5:0], 2'b00};
			5'h01: crc_word = {2'b01, c[11:6], 2'b00};
			default: crc_word = {4'h4, c[15:12], 2'b00};
			endcase
		end
	endfunction

	always @* begin
		if (idx_r < `UDW_FFCRC)
			exp_w = crc_word(ap_crc, idx_r);
		else
			exp_w = crc_word(ff_crc, idx_r - `UDW_FFCRC);
		w = d_in;
		if (st_r == S_UDW && crc_pos && edh_fix_on)
			w = exp_w;
		else if (st_r == S_SUM && fix_r)
			w = {~sum_r[8], sum_r};
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= S_IDLE;
			sum_r <= `RST9;
			left_r <= `RST8;
			idx_r <= `RST5;
			edh_r <= 1'b0;
			fix_r <= 1'b0;
			bad_r <= 1'b0;
			d_out_r <= `W_ZERO;
			ind_r <= 1'b0;
			edh_end_r <= 1'b0;
			edh_ok_r <= 1'b0;
			edh_set_r <= `RST15;
		end else begin
			d_out_r <= w;
			edh_end_r <= 1'b0;
			edh_ok_r <= 1'b0;
			case (st_r)
			S_IDLE: st_r <= (d_in == `W_ZERO) ? S_A1 : S_IDLE;
			S_A1: st_r <= (d_in == `W_ONES) ? S_A2 : (d_in == `W_ZERO) ? S_A1 : S_IDLE;
			S_A2: st_r <= (d_in == `W_ONES) ? S_DID : S_IDLE;
			S_DID: begin
				st_r <= S_SDID;
				sum_r <= w[8:0];
				edh_r <= edh_in;
				bad_r <= 1'b0;
				idx_r <= `RST5;
				ind_r <= did_hit;
				fix_r <= (sum_fix_on && did_hit) || (edh_in && edh_fix_on);
			end
			S_SDID: begin
				st_r <= S_DC;
				sum_r <= sum_r + w[8:0];
			end
			S_DC: begin
				st_r <= (d_in[7:0] == 8'h00) ? S_SUM : S_UDW;
				left_r <= d_in[7:0];
				sum_r <= sum_r + w[8:0];
			end
			S_UDW: begin
				sum_r <= sum_r + w[8:0];
				idx_r <= idx_r + 5'h01;
				left_r <= left_r - 8'h01;
				if (left_r == 8'h01)
					st_r <= S_SUM;
				if (crc_pos && edh_chk_on && d_in[8] && d_in[7:2] != exp_w[7:2])
					bad_r <= 1'b1;
				if (edh_r && idx_r == `UDW_ANC)
					edh_set_r[`F_ANC] <= d_in[`F_RX];
				if (edh_r && idx_r == `UDW_AP)
					edh_set_r[`F_AP] <= d_in[`F_RX];
				if (edh_r && idx_r == `UDW_FF)
					edh_set_r[`F_FF] <= d_in[`F_RX];
			end
			S_SUM: begin
				st_r <= S_IDLE;
				ind_r <= 1'b0;
				edh_end_r <= edh_r;
				edh_ok_r <= edh_r && !bad_r;
			end
			default: st_r <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: sim/vid_fix_asserts.sv
// concurrent checks on the stream corrector's register port and stream
`timescale 1ns/1ps
`default_nettype none
module vid_fix_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// apb
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata_r,
	input wire logic pready_r,
	input wire logic pslverr_r,
	// stream
	input wire logic smpte_mode,
	input wire logic [9:0] luma_in,
	input wire logic [9:0] chroma_in,
	input wire logic [9:0] luma_out_r,
	input wire logic [9:0] chroma_out_r,
	input wire logic luma_anc_indicator_r
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	wire [9:0] idx = paddr[11:2];

	a_one_wait: assert property (psel && penable && !pready_r |=> pready_r)
		else $error("apb answer missing after one wait");
	a_ready_pulse: assert property (pready_r |=> !pready_r)
		else $error("apb ready longer than one cycle");
	a_ready_cause: assert property (pready_r |-> psel && penable && $past(psel && penable))
		else $error("apb ready without access");
	a_err_unmapped: assert property (pready_r |-> pslverr_r == !(idx == 0 || idx == 3 || idx == 5))
		else $error("apb error flag wrong");
	a_flags_ro: assert property (pready_r && !pwrite && idx == 10'h003 |-> prdata_r[31:15] == 0)
		else $error("flag word upper bits set");
	a_dis_mask: assert property (pready_r && !pwrite && idx == 10'h000 |-> (prdata_r & ~32'h13F) == 0)
		else $error("disable word unused bits set");
	a_pass_through: assert property ((!smpte_mode)[*4] |->
		luma_out_r == $past(luma_in, 3) && chroma_out_r == $past(chroma_in, 3))
		else $error("stream changed outside smpte mode");
	a_ind_len: assert property ($rose(luma_anc_indicator_r) |-> luma_anc_indicator_r[*4])
		else $error("indicator shorter than a packet");
endmodule
bind vid_fix vid_fix_asserts i_vid_fix_asserts (.clk, .arst_n, .paddr, .psel, .penable, .pwrite,
	.prdata_r, .pready_r, .pslverr_r, .smpte_mode, .luma_in, .chroma_in, .luma_out_r,
	.chroma_out_r, .luma_anc_indicator_r);
`default_nettype wire

// file: sim/vid_fix_sink.sv
// downstream consumer model: counts packet ends on the indicators
`timescale 1ns/1ps
`default_nettype none
module vid_fix_sink (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// indicators
	input wire logic luma_ind,
	input wire logic chroma_ind,
	// packet ends seen
	output var int pkt_cnt
);
	logic seen_r;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_r <= 1'h0;
			pkt_cnt <= 0;
		end else begin
			seen_r <= luma_ind | chroma_ind;
			// falling edge: packet over, flags safe to read
			if (seen_r && !(luma_ind | chroma_ind))
				pkt_cnt <= pkt_cnt + 1;
		end
	end
endmodule
`default_nettype wire

// file: sim/test_video_error_correct_edh_flags.sv
// self-checking bench of the stream corrector
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_video_error_correct_edh_flags;
	logic clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata_r, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready_r, pslverr_r, er, h_blank_out_r, l_ind, c_ind;
	logic proc_enable_pin = 1'h1, flywheel_enable_pin = 1'h1, rate_select = 1'h1;
	logic smpte_mode = 1'h1, fw_eav = 1'h0, fw_v = 1'h0, fw_h = 1'h0, fw_active = 1'h0;
	logic rx_h = 1'h0;
	logic [10:0] fw_line = 11'h000;
	logic [9:0] luma_in = 10'h000, luma_out_r, chroma_out_r;
	int num_errors = 0, checks = 0, pkt_cnt;
	typedef struct packed {
		logic [15:0] dis; logic [1:0] en; logic act; logic fwh; logic rxh;
		logic [9:0] din; logic [9:0] ex; logic hb;
	} row_t;
	// en is {smpte mode, enable pin}; hb follows fw_h, or rx_h when bit 8 is set
	row_t rows [12] = '{
		'{16'h0000, 2'h3, 1'h1, 1'h0, 1'h1, 10'h3FC, 10'h3FB, 1'h0},
		'{16'h0000, 2'h3, 1'h1, 1'h1, 1'h0, 10'h3FF, 10'h3FB, 1'h1},
		'{16'h0000, 2'h3, 1'h1, 1'h0, 1'h0, 10'h000, 10'h004, 1'h0},
		'{16'h0000, 2'h3, 1'h1, 1'h0, 1'h0, 10'h003, 10'h004, 1'h0},
		'{16'h0000, 2'h3, 1'h1, 1'h0, 1'h0, 10'h200, 10'h200, 1'h0},
		'{16'h0100, 2'h3, 1'h1, 1'h0, 1'h1, 10'h3FD, 10'h3FB, 1'h1},
		'{16'h0100, 2'h3, 1'h1, 1'h1, 1'h0, 10'h001, 10'h004, 1'h0},
		'{16'h0020, 2'h3, 1'h1, 1'h0, 1'h0, 10'h3FE, 10'h3FE, 1'h0},
		'{16'h0000, 2'h3, 1'h0, 1'h0, 1'h0, 10'h3FE, 10'h3FF, 1'h0},
		'{16'h0000, 2'h3, 1'h0, 1'h0, 1'h0, 10'h002, 10'h000, 1'h0},
		'{16'h0000, 2'h2, 1'h1, 1'h0, 1'h0, 10'h3FC, 10'h3FC, 1'h0},
		'{16'h0000, 2'h1, 1'h1, 1'h0, 1'h0, 10'h000, 10'h000, 1'h0}};
	logic [9:0] ev [6] = '{10'h3FF, 10'h000, 10'h000, 10'h2D8, 10'h23C, 10'h204};

	vid_fix i_vid_fix (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
		.proc_enable_pin(proc_enable_pin), .flywheel_enable_pin(flywheel_enable_pin),
		.rate_select(rate_select), .smpte_mode(smpte_mode), .fw_eav(fw_eav),
		.fw_sav(1'h0), .fw_f(1'h0), .fw_v(fw_v), .fw_h(fw_h), .fw_active(fw_active),
		.fw_line(fw_line), .ap_range(1'h0), .ff_range(1'h0), .rx_h(rx_h),
		.luma_in(luma_in), .chroma_in(10'h200), .luma_out_r(luma_out_r),
		.chroma_out_r(chroma_out_r), .h_blank_out_r(h_blank_out_r),
		.luma_anc_indicator_r(l_ind), .chroma_anc_indicator_r(c_ind));
	vid_fix_sink i_vid_fix_sink (.clk(clk), .arst_n(arst_n), .luma_ind(l_ind),
		.chroma_ind(c_ind), .pkt_cnt(pkt_cnt));

	always #2 clk = ~clk;

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		// look at ready between edges, then complete on the next rising edge
		do begin
			@(negedge clk);
			n++;
		end while (pready_r !== 1'h1 && n < 16);
		if (pready_r !== 1'h1) begin
			num_errors++;
			finish_test();
		end
		@(posedge clk);
		rd = prdata_r;
		er = pslverr_r;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	function automatic logic [9:0] cs(input logic [9:0] a [23]);
		logic [8:0] s;
		s = 9'h000;
		for (int k = 3; k < 22; k++) s = s + a[k][8:0];
		return {~s[8], s};
	endfunction

	// one packet on luma; non-edh packets carry a wrong checksum on purpose
	task automatic pkt(input logic [9:0] did, input logic [4:0] fa, fp, ff,
		input logic bad, fix);
		logic [9:0] w [23];
		logic [9:0] o [23];
		for (int k = 0; k < 23; k++) w[k] = 10'h200;
		w[0] = 10'h000;
		w[1] = 10'h3FF;
		w[2] = 10'h3FF;
		w[3] = did;
		w[5] = 10'h110;
		w[6] = bad ? 10'h1FC : 10'h200;
		w[12] = {3'h4, fa, 2'h0};
		w[13] = {3'h4, fp, 2'h0};
		w[14] = {3'h4, ff, 2'h0};
		w[22] = cs(w) ^ {9'h000, did != 10'h1F4};
		o = w;
		if (did == 10'h1F4)
			for (int k = 6; k < 12; k++) o[k] = 10'h100;
		o[22] = fix ? cs(o) : w[22];
		for (int k = 0; k < 26; k++) begin
			@(posedge clk);
			luma_in <= (k < 23) ? w[k] : 10'h200;
			#1;
			if (k >= 9 && k < 15) `CHK(luma_out_r, o[k - 3])
			if (k >= 15 && k < 18) `CHK(luma_out_r, o[k - 3])
			if (k == 25) `CHK(luma_out_r, o[22])
		end
		repeat (8) @(posedge clk);
	endtask

	// hd timing reference and line number insertion, flywheel on or off
	task automatic trs(input logic fwp);
		rate_select <= 1'h0;
		flywheel_enable_pin <= fwp;
		fw_v <= 1'h1;
		fw_h <= 1'h1;
		fw_active <= 1'h0;
		fw_line <= 11'h08F;
		luma_in <= 10'h155;
		repeat (4) @(posedge clk);
		fw_eav <= 1'h1;
		@(posedge clk);
		fw_eav <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
		for (int k = 0; k < 6; k++) begin
			if (k < 4) `CHK(luma_out_r, fwp ? ev[k] : 10'h155)
			if (k >= 4) `CHK(luma_out_r, ev[k])
			if (k >= 4) `CHK(chroma_out_r, ev[k])
			@(posedge clk);
			#1;
		end
		luma_in <= 10'h200;
		$display("timing words done, flywheel %0d", fwp);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'h1;
		apb(12'h000, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h00000000)
		apb(12'h00C, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h00000000)
		apb(12'h000, 1'h1, 32'hFFFFFFFF, 4'hF);
		apb(12'h000, 1'h1, 32'h00000000, 4'h1);
		apb(12'h000, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h00000100)
		apb(12'h00C, 1'h1, 32'hFFFFFFFF, 4'hF);
		apb(12'h00C, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h00000000)
		apb(12'h008, 1'h0, 32'h0, 4'hF);
		`CHK({er, rd}, 33'h100000000)
		apb(12'h014, 1'h1, 32'hFFFFFFFF, 4'hF);
		apb(12'h014, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h000003FF)
		$display("registers done");
		for (int i = 0; i < 12; i++) begin
			apb(12'h000, 1'h1, {16'h0000, rows[i].dis}, 4'hF);
			@(posedge clk);
			smpte_mode <= rows[i].en[1];
			proc_enable_pin <= rows[i].en[0];
			fw_active <= rows[i].act;
			fw_h <= rows[i].fwh;
			rx_h <= rows[i].rxh;
			repeat (4) @(posedge clk);
			luma_in <= rows[i].din;
			@(posedge clk);
			luma_in <= 10'h200;
			repeat (2) @(posedge clk);
			#1;
			`CHK(luma_out_r, rows[i].ex)
			`CHK(h_blank_out_r, rows[i].hb)
			$display("row %0d done", i);
		end
		apb(12'h000, 1'h1, 32'h0, 4'hF);
		smpte_mode <= 1'h1;
		proc_enable_pin <= 1'h1;
		trs(1'h1);
		trs(1'h0);
		rate_select <= 1'h1;
		fw_v <= 1'h0;
		apb(12'h014, 1'h1, 32'h000001F4, 4'hF);
		pkt(10'h1F4, 5'h15, 5'h0A, 5'h1F, 1'h0, 1'h1);
		`CHK(pkt_cnt, 1)
		apb(12'h00C, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h000057EA)
		apb(12'h00C, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h000057EA)
		pkt(10'h1F4, 5'h03, 5'h03, 5'h03, 1'h1, 1'h1);
		apb(12'h00C, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h000057EA)
		pkt(10'h1F4, 5'h01, 5'h02, 5'h04, 1'h0, 1'h1);
		apb(12'h00C, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h00000482)
		pkt(10'h2E5, 5'h1F, 5'h1F, 5'h1F, 1'h0, 1'h0);
		`CHK(pkt_cnt, 3)
		apb(12'h014, 1'h1, 32'h0, 4'hF);
		pkt(10'h2E5, 5'h1F, 5'h1F, 5'h1F, 1'h0, 1'h1);
		apb(12'h00C, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h00000482)
		$display("packets done");
		@(posedge clk);
		arst_n <= 1'h0;
		repeat (2) @(posedge clk);
		arst_n <= 1'h1;
		apb(12'h00C, 1'h0, 32'h0, 4'hF);
		`CHK(rd, 32'h00000000)
		$display("reset done");
		finish_test();
	end
endmodule
`default_nettype wire
